//--- servo_fault_consts.svh
`ifndef SERVO_FAULT_CONSTS_SVH
`define SERVO_FAULT_CONSTS_SVH

`define CLK_HZ 50000000
`define BUS_OV_TIME_MS 6
`define AMB_OT_TIME_MS 3000
`define BRIDGE_OT_TIME_MS 300
`define MOTOR_OT_TIME_MS 300
`define COMM_ADJ_TIME_MS 3000
`define CYCLES_PER_MS (`CLK_HZ / 1000)
`define BUS_OV_CYCLES (`BUS_OV_TIME_MS * `CYCLES_PER_MS)
`define AMB_OT_CYCLES (`AMB_OT_TIME_MS * `CYCLES_PER_MS)
`define BRIDGE_OT_CYCLES (`BRIDGE_OT_TIME_MS * `CYCLES_PER_MS)
`define MOTOR_OT_CYCLES (`MOTOR_OT_TIME_MS * `CYCLES_PER_MS)
`define COMM_ADJ_CYCLES (`COMM_ADJ_TIME_MS * `CYCLES_PER_MS)

`define FB_SEL_ENCODER 2'h2

`define ENC_BIT_COMM 0
`define ENC_BIT_LOSS 1
`define ENC_BIT_TYPE 2
`define ENC_BIT_GAIN 3
`define ENC_BIT_OFFSET 4

`define FLT_SHORT 0
`define FLT_BUS_OV 1
`define FLT_REGEN 2
`define FLT_AMB_OT 3
`define FLT_BRIDGE_OT 4
`define FLT_MOTOR_OT 5
`define FLT_ENCODER 6
`define NUM_FAULTS 7

`define REG_CTRL 12'h000
`define REG_LIMIT_BUS 12'h004
`define REG_LIMIT_REGEN 12'h008
`define REG_LIMIT_AMB 12'h00C
`define REG_LIMIT_BRIDGE 12'h010
`define REG_LIMIT_MOTOR 12'h014
`define REG_LIMIT_ENC 12'h018
`define REG_FAULT 12'h01C
`define REG_ENC_MASK 12'h020
`define REG_IRQ_STATUS 12'h024
`define REG_IRQ_MASK 12'h028
`define REG_ADJ_STATUS 12'h02C

`define CTRL_CLEAR 0
`define CTRL_SW_ENABLE 1
`define CTRL_ADJ_START 2
`define CTRL_TORQUE 3

`endif

//--- servo_fault_pkg.sv
package servo_fault_pkg;
  typedef enum logic [2:0] {
    ADJ_IDLE = 3'h1,
    ADJ_ARMED = 3'h2,
    ADJ_RUN = 3'h4
  } adj_state_e;
endpackage

//--- qual_timer.sv
`timescale 1ns/1ps
// raises qualified once cond has held continuously for more than LIMIT cycles
module qual_timer #(
  parameter int LIMIT = 300000
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic cond,
  output logic qualified
);
  localparam int W = $clog2(LIMIT + 2);
  logic [W-1:0] count;
  logic [W-1:0] next_count;

  always_comb begin
    if (!cond) begin
      next_count = '0;
    end else if (count <= W'(LIMIT)) begin
      next_count = count + W'(1);
    end else begin
      next_count = count;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign qualified = cond && (count > W'(LIMIT));

  restart_on_drop_a: assert property (@(posedge clk) disable iff (srst)
    !cond |=> count == '0)
    else $error("timer did not restart on condition drop");
endmodule

//--- apb_regs.sv
`timescale 1ns/1ps
`include "servo_fault_consts.svh"
// apb slave: zero wait state, unmapped reads zero with pslverr
module apb_regs (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] rdataIn,
  input wire logic hit,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output logic wrStrobe,
  output logic rdStrobe
);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = (psel && penable && !pwrite && hit) ? rdataIn : 32'h0;
  assign wrStrobe = psel && penable && pwrite && hit;
  assign rdStrobe = psel && penable && !pwrite && hit;
endmodule

//--- servo_fault_monitor.sv
`timescale 1ns/1ps
`include "servo_fault_consts.svh"
module servo_fault_monitor #(
  parameter int DW = 16,
  parameter int BUS_OV_CYC = `BUS_OV_CYCLES,
  parameter int AMB_OT_CYC = `AMB_OT_CYCLES,
  parameter int BRIDGE_OT_CYC = `BRIDGE_OT_CYCLES,
  parameter int MOTOR_OT_CYC = `MOTOR_OT_CYCLES,
  parameter int ADJ_CYC = `COMM_ADJ_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire logic regenShortPin,
  input wire logic upperShortPin,
  input wire logic lowerShortPin,
  input wire logic hwEnablePin,
  input wire logic clearInputPin,
  input wire logic fieldbusClear,
  input wire logic [DW-1:0] busVoltage,
  input wire logic regenInitFail,
  input wire logic [DW-1:0] regenPower,
  input wire logic [DW-1:0] ambientTemp,
  input wire logic [DW-1:0] bridgeTemp,
  input wire logic [DW-1:0] motorTemp,
  input wire logic [1:0] commFeedbackSel,
  input wire logic [1:0] posFeedbackSel,
  input wire logic [1:0] velFeedbackSel,
  input wire logic encCommFault,
  input wire logic encTypeFault,
  input wire logic encGainFault,
  input wire logic encOffsetFault,
  input wire logic signed [DW-1:0] encSine,
  input wire logic signed [DW-1:0] encCosine,
  output logic [`NUM_FAULTS-1:0] faultStatus,
  output logic [4:0] encoderFaultWord,
  output logic driveEnable,
  output logic adjActive,
  output logic adjDone,
  output logic irq
);
  // pins from outside: two-stage synchronisers
  logic [4:0] syncA;
  logic [4:0] syncB;
  always_ff @(posedge clk) begin
    if (srst) begin
      syncA <= 5'h00;
      syncB <= 5'h00;
    end else begin
      syncA <= {clearInputPin, hwEnablePin, lowerShortPin, upperShortPin, regenShortPin};
      syncB <= syncA;
    end
  end
  logic regenShort, upperShort, lowerShort, hwEnable, clearInput;
  assign {clearInput, hwEnable, lowerShort, upperShort, regenShort} = syncB;

  // software registers
  logic swClear, swEnable, adjStart, torqueMode;
  logic [DW-1:0] limBus, limRegen, limAmb, limBridge, limMotor;
  logic [2*DW-1:0] limEnc;
  logic [`NUM_FAULTS-1:0] irqStatus, irqMask;
  logic next_swClear, next_swEnable, next_adjStart, next_torqueMode;
  logic [DW-1:0] next_limBus, next_limRegen, next_limAmb, next_limBridge, next_limMotor;
  logic [2*DW-1:0] next_limEnc;
  logic [`NUM_FAULTS-1:0] next_irqStatus, next_irqMask;

  logic wrStrobe, rdStrobe, hit;
  logic [31:0] rdata;
  apb_regs u_apb (
    .clk(clk),
    .srst(srst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .rdataIn(rdata),
    .hit(hit),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe)
  );

  // qualified conditions
  logic busOvQ, ambQ, bridgeQ, motorQ;
  qual_timer #(.LIMIT(BUS_OV_CYC)) u_busTimer (
    .clk(clk), .srst(srst), .cond(busVoltage > limBus), .qualified(busOvQ));
  qual_timer #(.LIMIT(AMB_OT_CYC)) u_ambTimer (
    .clk(clk), .srst(srst), .cond(ambientTemp > limAmb), .qualified(ambQ));
  qual_timer #(.LIMIT(BRIDGE_OT_CYC)) u_bridgeTimer (
    .clk(clk), .srst(srst), .cond(bridgeTemp > limBridge), .qualified(bridgeQ));
  qual_timer #(.LIMIT(MOTOR_OT_CYC)) u_motorTimer (
    .clk(clk), .srst(srst), .cond(motorTemp > limMotor), .qualified(motorQ));

  // encoder amplitude: sum of squares registered to keep the multiplier path short
  logic [2*DW:0] sumSq;
  logic [2*DW:0] next_sumSq;
  always_comb begin
    next_sumSq = (2*DW+1)'(encSine * encSine) + (2*DW+1)'(encCosine * encCosine);
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      sumSq <= '1;
    end else begin
      sumSq <= next_sumSq;
    end
  end

  logic ampLoss;
  assign ampLoss = sumSq < {1'b0, limEnc};
  logic [4:0] encWord;
  always_comb begin
    encWord = 5'h00;
    encWord[`ENC_BIT_COMM] = encCommFault;
    encWord[`ENC_BIT_LOSS] = ampLoss;
    encWord[`ENC_BIT_TYPE] = encTypeFault;
    encWord[`ENC_BIT_GAIN] = encGainFault;
    encWord[`ENC_BIT_OFFSET] = encOffsetFault;
  end
  logic encSelected;
  assign encSelected = (commFeedbackSel == `FB_SEL_ENCODER) ||
                       (posFeedbackSel == `FB_SEL_ENCODER) ||
                       (velFeedbackSel == `FB_SEL_ENCODER);

  logic [`NUM_FAULTS-1:0] raw;
  always_comb begin
    raw = '0;
    raw[`FLT_SHORT] = regenShort || upperShort || lowerShort;
    raw[`FLT_BUS_OV] = busOvQ;
    raw[`FLT_REGEN] = regenInitFail || (regenPower > limRegen);
    raw[`FLT_AMB_OT] = ambQ;
    raw[`FLT_BRIDGE_OT] = bridgeQ;
    raw[`FLT_MOTOR_OT] = motorQ;
    raw[`FLT_ENCODER] = encSelected && (encWord != 5'h00);
  end

  logic clearReq;
  assign clearReq = fieldbusClear || clearInput || swClear;

  // latched flags: a still-present condition wins over the clear
  logic [`NUM_FAULTS-1:0] faults;
  logic [`NUM_FAULTS-1:0] next_faults;
  logic [4:0] next_encoderFaultWord;
  always_comb begin
    next_faults = (clearReq ? '0 : faults) | raw;
    next_encoderFaultWord = (clearReq ? 5'h00 : encoderFaultWord) |
                            (encSelected ? encWord : 5'h00);
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      faults <= '0;
      encoderFaultWord <= 5'h00;
    end else begin
      faults <= next_faults;
      encoderFaultWord <= next_encoderFaultWord;
    end
  end
  assign faultStatus = faults;

  // commutation-offset adjustment sequencer
  servo_fault_pkg::adj_state_e adjState, next_adjState;
  localparam int AW = $clog2(ADJ_CYC + 1);
  logic [AW-1:0] adjCount, next_adjCount;
  logic adjDoneR, next_adjDoneR;
  logic enableRaw;
  assign enableRaw = hwEnable && swEnable;
  always_comb begin
    next_adjState = adjState;
    next_adjCount = adjCount;
    next_adjDoneR = adjDoneR;
    case (adjState)
      servo_fault_pkg::ADJ_IDLE: begin
        if (adjStart && torqueMode && (faults == '0)) begin
          next_adjState = servo_fault_pkg::ADJ_ARMED;
          next_adjDoneR = 1'b0;
        end
      end
      servo_fault_pkg::ADJ_ARMED: begin
        if (!torqueMode) begin
          next_adjState = servo_fault_pkg::ADJ_IDLE;
        end else if (enableRaw) begin
          next_adjState = servo_fault_pkg::ADJ_RUN;
          next_adjCount = '0;
        end
      end
      servo_fault_pkg::ADJ_RUN: begin
        // losing enable or a fault aborts the run without completion
        if (!enableRaw || (faults != '0)) begin
          next_adjState = servo_fault_pkg::ADJ_IDLE;
        end else if (adjCount == AW'(ADJ_CYC - 1)) begin
          next_adjState = servo_fault_pkg::ADJ_IDLE;
          next_adjDoneR = 1'b1;
        end else begin
          next_adjCount = adjCount + AW'(1);
        end
      end
      default: begin
        next_adjState = servo_fault_pkg::ADJ_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      adjState <= servo_fault_pkg::ADJ_IDLE;
      adjCount <= '0;
      adjDoneR <= 1'b0;
      driveEnable <= 1'b0;
    end else begin
      adjState <= next_adjState;
      adjCount <= next_adjCount;
      adjDoneR <= next_adjDoneR;
      driveEnable <= enableRaw;
    end
  end
  assign adjActive = (adjState == servo_fault_pkg::ADJ_RUN);
  assign adjDone = adjDoneR;

  // register file
  always_comb begin
    hit = 1'b1;
    rdata = 32'h0;
    case (paddr)
      `REG_CTRL: rdata = {28'h0, torqueMode, adjStart, swEnable, swClear};
      `REG_LIMIT_BUS: rdata = 32'(limBus);
      `REG_LIMIT_REGEN: rdata = 32'(limRegen);
      `REG_LIMIT_AMB: rdata = 32'(limAmb);
      `REG_LIMIT_BRIDGE: rdata = 32'(limBridge);
      `REG_LIMIT_MOTOR: rdata = 32'(limMotor);
      `REG_LIMIT_ENC: rdata = 32'(limEnc);
      `REG_FAULT: rdata = 32'(faults);
      `REG_ENC_MASK: rdata = {27'h0, encoderFaultWord};
      `REG_IRQ_STATUS: rdata = 32'(irqStatus);
      `REG_IRQ_MASK: rdata = 32'(irqMask);
      `REG_ADJ_STATUS: rdata = {30'h0, adjActive, adjDoneR};
      default: hit = 1'b0;
    endcase
  end

  logic [`NUM_FAULTS-1:0] riseEvt;
  assign riseEvt = next_faults & ~faults;
  always_comb begin
    next_swClear = 1'b0;
    next_swEnable = swEnable;
    next_adjStart = (adjState == servo_fault_pkg::ADJ_IDLE) ? adjStart : 1'b0;
    next_torqueMode = torqueMode;
    next_limBus = limBus;
    next_limRegen = limRegen;
    next_limAmb = limAmb;
    next_limBridge = limBridge;
    next_limMotor = limMotor;
    next_limEnc = limEnc;
    next_irqMask = irqMask;
    next_irqStatus = irqStatus;
    if (rdStrobe && (paddr == `REG_IRQ_STATUS)) begin
      next_irqStatus = '0;
    end
    next_irqStatus = next_irqStatus | riseEvt;
    if (wrStrobe) begin
      case (paddr)
        `REG_CTRL: begin
          next_swClear = pwdata[`CTRL_CLEAR];
          next_swEnable = pwdata[`CTRL_SW_ENABLE];
          next_adjStart = pwdata[`CTRL_ADJ_START];
          next_torqueMode = pwdata[`CTRL_TORQUE];
        end
        `REG_LIMIT_BUS: next_limBus = pwdata[DW-1:0];
        `REG_LIMIT_REGEN: next_limRegen = pwdata[DW-1:0];
        `REG_LIMIT_AMB: next_limAmb = pwdata[DW-1:0];
        `REG_LIMIT_BRIDGE: next_limBridge = pwdata[DW-1:0];
        `REG_LIMIT_MOTOR: next_limMotor = pwdata[DW-1:0];
        `REG_LIMIT_ENC: next_limEnc = 32'(pwdata) > 0 ? (2*DW)'(pwdata) : '0;
        `REG_IRQ_MASK: next_irqMask = pwdata[`NUM_FAULTS-1:0];
        default: begin
        end
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      swClear <= 1'b0;
      swEnable <= 1'b0;
      adjStart <= 1'b0;
      torqueMode <= 1'b0;
      limBus <= '1;
      limRegen <= '1;
      limAmb <= '1;
      limBridge <= '1;
      limMotor <= '1;
      limEnc <= '0;
      irqMask <= '0;
      irqStatus <= '0;
      irq <= 1'b0;
    end else begin
      swClear <= next_swClear;
      swEnable <= next_swEnable;
      adjStart <= next_adjStart;
      torqueMode <= next_torqueMode;
      limBus <= next_limBus;
      limRegen <= next_limRegen;
      limAmb <= next_limAmb;
      limBridge <= next_limBridge;
      limMotor <= next_limMotor;
      limEnc <= next_limEnc;
      irqMask <= next_irqMask;
      irqStatus <= next_irqStatus;
      irq <= |(next_irqStatus & next_irqMask);
    end
  end

  fault_hold_a: assert property (@(posedge clk) disable iff (srst)
    faults[`FLT_SHORT] && !clearReq |=> faults[`FLT_SHORT])
    else $error("latched fault dropped without clear");
  short_set_a: assert property (@(posedge clk) disable iff (srst)
    regenShort || upperShort || lowerShort |=> faults[`FLT_SHORT])
    else $error("short circuit not latched");
  clear_path_a: assert property (@(posedge clk) disable iff (srst)
    clearReq && raw == '0 |=> faults == '0)
    else $error("clear did not empty the fault flags");
  reassert_a: assert property (@(posedge clk) disable iff (srst)
    clearReq && raw != '0 |=> (faults & $past(raw)) == $past(raw))
    else $error("qualified fault lost on clear");
  regen_set_a: assert property (@(posedge clk) disable iff (srst)
    regenInitFail |=> faults[`FLT_REGEN])
    else $error("regen fault not latched");
  enc_gate_a: assert property (@(posedge clk) disable iff (srst)
    !encSelected && !faults[`FLT_ENCODER] && !clearReq |=> !faults[`FLT_ENCODER])
    else $error("encoder fault without encoder feedback");
  enable_gate_a: assert property (@(posedge clk) disable iff (srst)
    driveEnable |-> $past(hwEnable) && $past(swEnable))
    else $error("drive enabled without both enables");
  adj_abort_a: assert property (@(posedge clk) disable iff (srst)
    adjActive && !enableRaw |=> !adjActive && !adjDone)
    else $error("adjustment ran on without enable");
  status_map_a: assert property (@(posedge clk) disable iff (srst)
    $rose(faults[`FLT_MOTOR_OT]) |-> $past(motorQ))
    else $error("motor fault shown without qualification");
endmodule

//--- servo_partner.sv
`timescale 1ns/1ps
module servo_partner (
  input wire logic clk,
  output logic regenShortPin,
  output logic upperShortPin,
  output logic lowerShortPin,
  output logic hwEnablePin,
  output logic clearInputPin,
  output logic fieldbusClear,
  output logic [15:0] busVoltage,
  output logic regenInitFail,
  output logic [15:0] regenPower,
  output logic [15:0] ambientTemp,
  output logic [15:0] bridgeTemp,
  output logic [15:0] motorTemp,
  output logic [1:0] commFeedbackSel,
  output logic [1:0] posFeedbackSel,
  output logic [1:0] velFeedbackSel,
  output logic encCommFault,
  output logic encTypeFault,
  output logic encGainFault,
  output logic encOffsetFault,
  output logic signed [15:0] encSine,
  output logic signed [15:0] encCosine
);
  initial begin
    {regenShortPin, upperShortPin, lowerShortPin, hwEnablePin} = 4'h0;
    {clearInputPin, fieldbusClear, regenInitFail} = 3'h0;
    {encCommFault, encTypeFault, encGainFault, encOffsetFault} = 4'h0;
    {commFeedbackSel, posFeedbackSel, velFeedbackSel} = 6'h00;
    busVoltage = 16'h0100;
    regenPower = 16'h0010;
    {ambientTemp, bridgeTemp, motorTemp} = {3{16'h0020}};
    encSine = 16'sh03E8;
    encCosine = 16'sh0000;
  end
  // nominal levels sit well inside the limits the bench programs
  task automatic setCond(input int k, input logic on);
    @(posedge clk);
    case (k)
      0: regenShortPin <= on;
      1: upperShortPin <= on;
      2: lowerShortPin <= on;
      3: busVoltage <= on ? 16'h0500 : 16'h0100;
      4: regenInitFail <= on;
      5: regenPower <= on ? 16'h0300 : 16'h0010;
      6: ambientTemp <= on ? 16'h0060 : 16'h0020;
      7: bridgeTemp <= on ? 16'h0060 : 16'h0020;
      8: motorTemp <= on ? 16'h0060 : 16'h0020;
      9: encCommFault <= on;
      10: begin
        encSine <= on ? 16'sh000A : 16'sh03E8;
        encCosine <= on ? 16'sh000A : 16'sh0000;
      end
      11: encTypeFault <= on;
      12: encGainFault <= on;
      default: encOffsetFault <= on;
    endcase
  endtask
  // digital input is asynchronous: held long enough for the synchroniser
  task automatic clearPulse(input int src);
    @(posedge clk);
    if (src == 0) fieldbusClear <= 1'b1;
    else clearInputPin <= 1'b1;
    repeat (src == 0 ? 1 : 3) @(posedge clk);
    fieldbusClear <= 1'b0;
    clearInputPin <= 1'b0;
  endtask
  task automatic setEnable(input logic on);
    @(posedge clk);
    hwEnablePin <= on;
  endtask
  task automatic setSel(input logic [1:0] sel);
    @(posedge clk);
    velFeedbackSel <= sel;
  endtask
endmodule

//--- servo_fault_monitor_test.sv
`timescale 1ns/1ps
`include "servo_fault_consts.svh"
module servo_fault_monitor_test;
  localparam int BUS_N = 8;
  localparam int AMB_N = 12;
  localparam int BRG_N = 6;
  localparam int MOT_N = 10;
  localparam int ADJ_N = 20;
  typedef struct {int k; int bitNo; int hold; logic [4:0] enc;} row_s;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic regenShortPin, upperShortPin, lowerShortPin, hwEnablePin, clearInputPin;
  logic fieldbusClear, regenInitFail, encCommFault, encTypeFault, encGainFault;
  logic encOffsetFault, driveEnable, adjActive, adjDone, irq;
  logic [15:0] busVoltage, regenPower, ambientTemp, bridgeTemp, motorTemp;
  logic [1:0] commFeedbackSel, posFeedbackSel, velFeedbackSel;
  logic signed [15:0] encSine, encCosine;
  logic [6:0] faultStatus;
  logic [4:0] encoderFaultWord;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  row_s r;
  row_s rows[14] = '{
    '{0, 0, 0, 5'h00}, '{1, 0, 0, 5'h00}, '{2, 0, 0, 5'h00},
    '{3, 1, BUS_N, 5'h00},
    '{4, 2, 0, 5'h00}, '{5, 2, 0, 5'h00},
    '{6, 3, AMB_N, 5'h00}, '{7, 4, BRG_N, 5'h00}, '{8, 5, MOT_N, 5'h00},
    '{9, 6, 0, 5'h01}, '{10, 6, 0, 5'h02}, '{11, 6, 0, 5'h04},
    '{12, 6, 0, 5'h08}, '{13, 6, 0, 5'h10}};

  servo_partner servo_partner_i (.*);
  servo_fault_monitor #(.DW(16), .BUS_OV_CYC(BUS_N), .AMB_OT_CYC(AMB_N),
    .BRIDGE_OT_CYC(BRG_N), .MOTOR_OT_CYC(MOT_N), .ADJ_CYC(ADJ_N))
    servo_fault_monitor_i (.*);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until the edge that samples pready high; data taken at that edge
  task automatic apbXfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ends off the edge so outputs are looked at once settled
  task automatic waitN(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic setLimits();
    apbXfer(`REG_LIMIT_BUS, 1'b1, 32'h0000_0400);
    apbXfer(`REG_LIMIT_REGEN, 1'b1, 32'h0000_0200);
    apbXfer(`REG_LIMIT_AMB, 1'b1, 32'h0000_0050);
    apbXfer(`REG_LIMIT_BRIDGE, 1'b1, 32'h0000_0050);
    apbXfer(`REG_LIMIT_MOTOR, 1'b1, 32'h0000_0050);
    apbXfer(`REG_LIMIT_ENC, 1'b1, 32'h0000_1000);
  endtask

  initial begin
    {srst, psel, penable, pwrite} = 4'h8;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    waitN(3);
    checkVal(faultStatus, 32'h0);
    apbXfer(`REG_FAULT, 1'b0, 32'h0);
    checkVal(rd, 32'h0);
    setLimits();
    servo_partner_i.setCond(9, 1'b1);
    waitN(6);
    checkVal({faultStatus, encoderFaultWord}, 32'h0);
    servo_partner_i.setCond(9, 1'b0);
    servo_partner_i.setSel(`FB_SEL_ENCODER);
    foreach (rows[i]) begin
      r = rows[i];
      servo_partner_i.setCond(r.k, 1'b1);
      if (r.hold > 0) begin
        waitN(r.hold - 2);
        servo_partner_i.setCond(r.k, 1'b0);
        servo_partner_i.setCond(r.k, 1'b1);
        waitN(r.hold);
        checkVal(faultStatus, 32'h0);
      end
      waitN(6);
      checkVal(faultStatus, 32'h1 << r.bitNo);
      checkVal(encoderFaultWord, r.enc);
      servo_partner_i.setCond(r.k, 1'b0);
      waitN(6);
      checkVal(faultStatus, 32'h1 << r.bitNo);
      if (i % 3 == 2) apbXfer(`REG_CTRL, 1'b1, 32'h1);
      else servo_partner_i.clearPulse(i % 3);
      waitN(6);
      checkVal({faultStatus, encoderFaultWord}, 32'h0);
    end
    servo_partner_i.setEnable(1'b1);
    apbXfer(`REG_CTRL, 1'b1, 32'hC);
    waitN(4);
    checkVal(driveEnable, 32'h0);
    apbXfer(`REG_CTRL, 1'b1, 32'hE);
    waitN(4);
    checkVal({driveEnable, adjActive}, 32'h3);
    waitN(ADJ_N + 4);
    checkVal({adjActive, adjDone}, 32'h1);
    apbXfer(`REG_ADJ_STATUS, 1'b0, 32'h0);
    checkVal(rd, 32'h1);
    apbXfer(`REG_CTRL, 1'b1, 32'hE);
    waitN(4);
    checkVal({adjActive, adjDone}, 32'h2);
    servo_partner_i.setEnable(1'b0);
    waitN(6);
    checkVal({adjActive, adjDone}, 32'h0);
    checkVal(driveEnable, 32'h0);
    apbXfer(`REG_CTRL, 1'b1, 32'h0);
    apbXfer(`REG_IRQ_STATUS, 1'b0, 32'h0);
    apbXfer(`REG_IRQ_MASK, 1'b1, 32'h1);
    servo_partner_i.setCond(0, 1'b1);
    waitN(6);
    checkVal(irq, 32'h1);
    apbXfer(`REG_IRQ_STATUS, 1'b0, 32'h0);
    checkVal(rd, 32'h1);
    waitN(2);
    checkVal(irq, 32'h0);
    servo_partner_i.setCond(7, 1'b1);
    waitN(BRG_N + 6);
    checkVal(irq, 32'h0);
    apbXfer(`REG_IRQ_STATUS, 1'b0, 32'h0);
    checkVal(rd, 32'h10);
    servo_partner_i.clearPulse(0);
    waitN(2);
    checkVal(faultStatus, 32'h11);
    apbXfer(`REG_FAULT, 1'b0, 32'h0);
    checkVal(rd, 32'h11);
    apbXfer(12'h030, 1'b0, 32'h0);
    checkVal(32'(err), 32'h1);
    checkVal(rd, 32'h0);
    // second reset in mid-run with faults latched
    srst <= 1'b1;
    servo_partner_i.setCond(0, 1'b0);
    servo_partner_i.setCond(7, 1'b0);
    waitN(2);
    checkVal({faultStatus, irq, driveEnable}, 32'h0);
    @(posedge clk);
    srst <= 1'b0;
    waitN(6);
    checkVal(faultStatus, 32'h0);
    end_of_test();
  end
endmodule
